// >>> logic/flash_host.v
// Host controller driving a four-bank parallel NOR flash through its pins
`timescale 1ns/1ns
`include "flash_host_regs.vh"
module flash_host #(
   parameter RESET_PULSE_CYC = `CYC_UP(`MIN_RESET_PULSE_NS),
   parameter RECOVERY_CYC = `CYC_UP(`RESET_RECOVERY_NS),
   parameter READY_TIMEOUT_CYC = `CYC_UP(`READY_EMBEDDED_NS),
   parameter ACCESS_CYC = `CYC_UP(`ADDRESS_ACCESS_NS) + 1,
   parameter WE_PULSE_CYC = `CYC_UP(`WRITE_PULSE_NS),
   parameter WE_RECOVER_CYC = `CYC_UP(`WRITE_RECOVERY_NS)
) (
   input wire I_CLK, // Clock, 100 MHz
   input wire I_ARST_N, // Async reset, active low
   input wire I_REQ_VALID, // Request strobe, one cycle
   input wire [1:0] I_REQ_OP, // Request opcode
   input wire [21:0] I_REQ_ADDR, // Word address, or byte address bits 22:1
   input wire I_REQ_ADDR_LSB, // Byte address LSB in byte width
   input wire [15:0] I_REQ_DATA, // Write or program data
   input wire I_BYTE_MODE, // 1 selects byte width
   input wire I_BYPASS, // Flash bank is in unlock-bypass or accelerated state
   input wire I_ACCEL_EN, // Request accel high voltage on protect pin
   input wire I_PROTECT_N, // Protect pin level outside acceleration
   output reg O_REQ_READY, // Idle, request may be taken
   output reg O_RSP_VALID, // Read data valid, one cycle
   output reg [15:0] O_RSP_DATA, // Read data
   output reg O_RSP_DONE, // Write, program or reset finished, one cycle
   output reg O_FLASH_BUSY, // Flash ready/busy shows busy
   output reg [21:0] O_A, // Flash address pins
   output reg O_CE_N, // Flash chip select
   output reg O_OE_N, // Flash output enable
   output reg O_WE_N, // Flash write enable
   output reg O_RESET_N, // Flash reset pin
   output reg O_WORD_MODE, // Flash width-select pin, 1 = word
   output reg O_PROTECT_ACCEL_PIN, // Protect pin logic level
   output reg O_ACCEL_HIGH_VOLTAGE, // Switch accel_high_voltage onto protect pin
   output reg [15:0] O_DQ, // Data lane outputs
   output reg [15:0] O_DQ_OE, // Data lane output enables, high = drive
   input wire [15:0] I_DQ, // Data lane inputs
   input wire I_READY_BUSY_N // Flash ready_busy_n pin
);
   localparam CW = 16;
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_RD = 7'h02;
   localparam [6:0] S_WR_LOW = 7'h04;
   localparam [6:0] S_WR_HIGH = 7'h08;
   localparam [6:0] S_RST_LOW = 7'h10;
   localparam [6:0] S_RST_WAIT = 7'h20;
   localparam [6:0] S_RST_REC = 7'h40;

   wire [16:0] pin_sync;
   reg [6:0] state_q;
   reg [CW-1:0] cnt_q;
   reg [2:0] step_q;
   reg [2:0] steps_q;
   reg prog_q;
   reg [21:0] addr_q;
   reg lsb_q;
   reg [15:0] data_q;
   wire [15:0] dq_in;
   wire rdy_in;
   reg [21:0] step_addr;
   reg [15:0] step_data;

   flash_sync2 #(.W(17)) u_sync (
      .i_clk(I_CLK),
      .i_arst_n(I_ARST_N),
      .i_async({I_READY_BUSY_N, I_DQ}),
      .o_sync(pin_sync)
   );
   assign dq_in = pin_sync[15:0];
   assign rdy_in = pin_sync[16];

   ////////////////////////////////////////////////////////////////////////////////
   // Program sequence: four cycles normally, last two only in bypass
   always @* begin
      step_addr = addr_q;
      step_data = data_q;
      if (prog_q) begin
         case (step_q + (steps_q == `PROG_CYCLES_BYPASS ? 3'h2 : 3'h0))
            3'h0: begin
               step_addr = `UNLOCK_ADDR1;
               step_data = `UNLOCK_DATA1;
            end
            3'h1: begin
               step_addr = `UNLOCK_ADDR2;
               step_data = `UNLOCK_DATA2;
            end
            3'h2: begin
               step_addr = `UNLOCK_ADDR1;
               step_data = `PROG_CMD_DATA;
            end
            default: begin
               step_addr = addr_q;
               step_data = data_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencer
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_q <= S_RST_LOW;
         cnt_q <= {CW{1'b0}};
         step_q <= 3'h0;
         steps_q <= 3'h1;
         prog_q <= 1'b0;
         addr_q <= 22'h000000;
         lsb_q <= 1'b0;
         data_q <= 16'h0000;
         O_REQ_READY <= 1'b0;
         O_RSP_VALID <= 1'b0;
         O_RSP_DATA <= 16'h0000;
         O_RSP_DONE <= 1'b0;
         O_FLASH_BUSY <= 1'b0;
         O_A <= 22'h000000;
         O_CE_N <= 1'b1;
         O_OE_N <= 1'b1;
         O_WE_N <= 1'b1;
         O_RESET_N <= 1'b0;
         O_WORD_MODE <= 1'b1;
         O_PROTECT_ACCEL_PIN <= 1'b0;
         O_ACCEL_HIGH_VOLTAGE <= 1'b0;
         O_DQ <= 16'h0000;
         O_DQ_OE <= 16'h0000;
      end else begin
         O_RSP_VALID <= 1'b0;
         O_RSP_DONE <= 1'b0;
         O_FLASH_BUSY <= ~rdy_in;
         O_PROTECT_ACCEL_PIN <= I_PROTECT_N;
         case (state_q)
            S_IDLE: begin
               // Strobes rest high: standby, flash outputs float
               O_CE_N <= 1'b1;
               O_OE_N <= 1'b1;
               O_WE_N <= 1'b1;
               O_DQ_OE <= 16'h0000;
               // Accel voltage only switched while idle or cleared in flash reset, never mid bus cycle
               O_ACCEL_HIGH_VOLTAGE <= I_ACCEL_EN;
               O_WORD_MODE <= ~I_BYTE_MODE;
               if (I_REQ_VALID && O_REQ_READY) begin
                  O_REQ_READY <= 1'b0;
                  addr_q <= I_REQ_ADDR;
                  lsb_q <= I_REQ_ADDR_LSB;
                  data_q <= I_REQ_DATA;
                  // High voltage is for programming only; other work runs without it
                  if (I_REQ_OP != `OP_PROG) begin
                     O_ACCEL_HIGH_VOLTAGE <= 1'b0;
                  end
                  step_q <= 3'h0;
                  cnt_q <= {CW{1'b0}};
                  prog_q <= (I_REQ_OP == `OP_PROG);
                  // Accel forces bypass, so the short path is used then
                  steps_q <= (I_REQ_OP != `OP_PROG) ? 3'h1 :
                     (I_BYPASS || O_ACCEL_HIGH_VOLTAGE) ? `PROG_CYCLES_BYPASS :
                     `PROG_CYCLES_NORMAL;
                  case (I_REQ_OP)
                     `OP_READ: state_q <= S_RD;
                     `OP_RESET: state_q <= S_RST_LOW;
                     default: state_q <= S_WR_LOW;
                  endcase
               end else begin
                  O_REQ_READY <= 1'b1;
               end
            end
            S_RD: begin
               // Full chip-select access time from standby
               O_A <= addr_q;
               O_CE_N <= 1'b0;
               O_OE_N <= 1'b0;
               O_WE_N <= 1'b1;
               O_DQ_OE <= {~O_WORD_MODE, 15'h0000};
               O_DQ <= {lsb_q, 15'h0000};
               cnt_q <= cnt_q + 1'b1;
               // Two extra cycles cover the input synchroniser
               if (cnt_q == ACCESS_CYC[CW-1:0] + 16'h0002) begin
                  O_RSP_DATA <= O_WORD_MODE ? dq_in : {8'h00, dq_in[7:0]};
                  O_RSP_VALID <= 1'b1;
                  O_CE_N <= 1'b1;
                  O_OE_N <= 1'b1;
                  O_DQ_OE <= 16'h0000;
                  state_q <= S_IDLE;
               end
            end
            S_WR_LOW: begin
               O_A <= step_addr;
               O_OE_N <= 1'b1;
               O_CE_N <= 1'b0;
               O_WE_N <= 1'b0;
               O_DQ <= O_WORD_MODE ? step_data : {lsb_q, 7'h00, step_data[7:0]};
               O_DQ_OE <= O_WORD_MODE ? 16'hffff : 16'h80ff;
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == WE_PULSE_CYC[CW-1:0]) begin
                  cnt_q <= {CW{1'b0}};
                  state_q <= S_WR_HIGH;
               end
            end
            S_WR_HIGH: begin
               O_WE_N <= 1'b1;
               O_CE_N <= 1'b1;
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == WE_RECOVER_CYC[CW-1:0]) begin
                  cnt_q <= {CW{1'b0}};
                  O_DQ_OE <= 16'h0000;
                  if (step_q + 3'h1 == steps_q) begin
                     O_RSP_DONE <= 1'b1;
                     state_q <= S_IDLE;
                  end else begin
                     step_q <= step_q + 3'h1;
                     state_q <= S_WR_LOW;
                  end
               end
            end
            S_RST_LOW: begin
               // Strobes high, data lanes released and accel cleared while the reset pulse is held
               O_RESET_N <= 1'b0;
               O_CE_N <= 1'b1;
               O_OE_N <= 1'b1;
               O_WE_N <= 1'b1;
               O_DQ_OE <= 16'h0000;
               O_ACCEL_HIGH_VOLTAGE <= 1'b0;
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == RESET_PULSE_CYC[CW-1:0]) begin
                  cnt_q <= {CW{1'b0}};
                  O_RESET_N <= 1'b1;
                  state_q <= S_RST_WAIT;
               end
            end
            S_RST_WAIT: begin
               // Busy stays low until internal reset ends; bounded by timeout
               cnt_q <= cnt_q + 1'b1;
               if (rdy_in || cnt_q == READY_TIMEOUT_CYC[CW-1:0]) begin
                  cnt_q <= {CW{1'b0}};
                  state_q <= S_RST_REC;
               end
            end
            S_RST_REC: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == RECOVERY_CYC[CW-1:0]) begin
                  // Flash back in array read; caller reissues cut-off work
                  O_RSP_DONE <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_RST_LOW;
         endcase
      end
   end
endmodule // flash_host

// >>> shared/flash_host_regs.vh
// Timing and encoding constants for the parallel flash host controller
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH
// Times in ns as specified; counts derived at 100 MHz
`define CLK_PERIOD_NS 10
`define MIN_RESET_PULSE_NS 500
`define RESET_RECOVERY_NS 50
`define READY_EMBEDDED_NS 20000
`define ADDRESS_ACCESS_NS 90
`define WRITE_PULSE_NS 40
`define WRITE_RECOVERY_NS 30
// Least times round up to whole cycles
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Request opcodes
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_PROG 2'h2
`define OP_RESET 2'h3
// Bus operation count for the two programming paths
`define PROG_CYCLES_NORMAL 3'h4
`define PROG_CYCLES_BYPASS 3'h2
// Command words of the program sequence (low byte only matters)
`define UNLOCK_ADDR1 22'h000555
`define UNLOCK_DATA1 16'h00aa
`define UNLOCK_ADDR2 22'h0002aa
`define UNLOCK_DATA2 16'h0055
`define PROG_CMD_DATA 16'h00a0
`endif

// >>> logic/flash_sync2.v
// Two-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ns
module flash_sync2 #(
   parameter W = 1
) (
   input wire i_clk, // Clock
   input wire i_arst_n, // Async reset, active low
   input wire [W-1:0] i_async, // Asynchronous pin levels
   output wire [W-1:0] o_sync // Synchronised levels
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule // flash_sync2

// >>> testbench/flash_host_props.sv
// Concurrent checks on the flash host controller pins
`timescale 1ns/1ns
module flash_host_props #(
   parameter RESET_PULSE_CYC = 3
) (
   input wire I_CLK, // Clock
   input wire I_ARST_N, // Reset, active low
   input wire I_REQ_VALID, // Request strobe
   input wire [1:0] I_REQ_OP, // Opcode
   input wire O_REQ_READY, // Idle
   input wire O_RSP_VALID, // Read answer
   input wire O_CE_N, // Chip select
   input wire O_OE_N, // Output enable
   input wire O_WE_N, // Write enable
   input wire O_RESET_N, // Flash reset
   input wire O_WORD_MODE, // Width select
   input wire O_ACCEL_HIGH_VOLTAGE, // Accel switch
   input wire [15:0] O_DQ_OE // Lane enables
);
   reg [7:0] low_q;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   ////////////////////////////////////////////////////////////////////////////////
   // Width is counted, a repeat of a parameter would not unroll
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) low_q <= 8'h00;
      else if (O_RESET_N) low_q <= 8'h00;
      else if (low_q != 8'hff) low_q <= low_q + 8'h01;
   end
   sequence rd_take;
      I_REQ_VALID && O_REQ_READY && I_REQ_OP == 2'h0;
   endsequence
   sequence rd_cycle;
      (!O_CE_N && !O_OE_N && O_WE_N) [*3];
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   read_walk_a: assert property (rd_take |-> ##[1:2] rd_cycle ##[1:6] O_RSP_VALID)
      else $error("read cycle malformed");
   read_levels_a: assert property (!O_OE_N |-> !O_CE_N && O_WE_N)
      else $error("read strobes wrong");
   read_float_a: assert property (O_WORD_MODE && !O_OE_N |-> O_DQ_OE == 16'h0000)
      else $error("host drives lanes in a read");
   write_levels_a: assert property (!O_WE_N |-> !O_CE_N && O_OE_N)
      else $error("write strobes wrong");
   byte_lanes_a: assert property (!O_WORD_MODE |-> O_DQ_OE[14:8] == 7'h00)
      else $error("upper lanes driven in byte width");
   byte_lsb_a: assert property (!O_WORD_MODE && !O_WE_N |-> O_DQ_OE[15])
      else $error("address lsb lane not driven");
   word_lanes_a: assert property (O_WORD_MODE && !O_WE_N |-> O_DQ_OE == 16'hffff)
      else $error("word write lanes not all driven");
   reset_quiet_a: assert property (!O_RESET_N |-> O_CE_N && O_OE_N && O_WE_N)
      else $error("strobes active in flash reset");
   reset_width_a: assert property ($rose(O_RESET_N) |-> {24'h0, low_q} >= RESET_PULSE_CYC)
      else $error("flash reset pulse too short");
   accel_only_a: assert property (O_ACCEL_HIGH_VOLTAGE |-> O_OE_N && O_RESET_N)
      else $error("high voltage outside programming");
   ready_after_a: assert property (O_RSP_VALID |=> O_REQ_READY)
      else $error("ready not back after read");
endmodule // flash_host_props
bind flash_host flash_host_props #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) props_u (
   .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_REQ_VALID(I_REQ_VALID), .I_REQ_OP(I_REQ_OP),
   .O_REQ_READY(O_REQ_READY), .O_RSP_VALID(O_RSP_VALID), .O_CE_N(O_CE_N),
   .O_OE_N(O_OE_N), .O_WE_N(O_WE_N), .O_RESET_N(O_RESET_N), .O_WORD_MODE(O_WORD_MODE),
   .O_ACCEL_HIGH_VOLTAGE(O_ACCEL_HIGH_VOLTAGE), .O_DQ_OE(O_DQ_OE));

// >>> testbench/flash_dev_model.sv
// Behavioural parallel flash seen from its pins
`timescale 1ns/1ns
module flash_dev_model (
   input wire i_clk, // Strobe sampling clock
   input wire [21:0] i_a, // Address
   input wire i_ce_n, // Chip select
   input wire i_oe_n, // Output enable
   input wire i_we_n, // Write enable
   input wire i_reset_n, // Reset pin
   input wire i_word_mode, // Width select
   input wire [15:0] i_dq, // Resolved lanes
   output wire [15:0] o_dq, // Lane drive, pattern where floating
   output wire o_ready_busy_n // Ready/busy
);
   reg [15:0] mem_q [0:15];
   reg [15:0] wd_q = 16'h0000;
   reg [3:0] wa_q = 4'h0;
   reg [3:0] busy_q = 4'h0;
   reg we_q = 1'b1;
   reg armed_q = 1'b0;
   reg tog_q = 1'b0;
   integer i;
   wire drive = !i_ce_n && !i_oe_n && i_reset_n;
   wire [15:0] word = mem_q[i_a[3:0]];
   // Floating lanes toggle so a stale value never looks valid
   wire [15:0] flt = tog_q ? 16'haaaa : 16'h5555;
   assign o_dq = !drive ? flt : i_word_mode ? word :
      {flt[15:8], i_dq[15] ? word[15:8] : word[7:0]};
   assign o_ready_busy_n = busy_q == 4'h0;
   initial begin
      for (i = 0; i < 16; i = i + 1) mem_q[i] = 16'ha5a0 | i;
   end
   always @(posedge i_clk) begin
      tog_q <= !tog_q;
      we_q <= i_we_n;
      if (!i_we_n) begin
         wa_q <= i_a[3:0];
         wd_q <= i_dq;
      end
      // Reset over a running operation keeps busy until internal reset ends
      if (!i_reset_n && busy_q != 4'h0) busy_q <= 4'ha;
      else if (busy_q != 4'h0) busy_q <= busy_q - 4'h1;
      if (!i_reset_n) armed_q <= 1'b0;
      else if (i_we_n && !we_q) begin
         // Any program command arms the next write, so the bypass pair works too
         armed_q <= wd_q[7:0] == 8'ha0;
         if (armed_q) begin
            mem_q[wa_q] <= wd_q;
            busy_q <= 4'ha;
         end
      end
   end
endmodule // flash_dev_model

// >>> testbench/flash_bus_operation_modes_bench.sv
// Self-checking bench for the flash host controller with a flash model
`timescale 1ns/1ns
module flash_bus_operation_modes_bench;
   reg clk, arst_n = 1'b0, valid = 1'b0, byte_m = 1'b0, bypass = 1'b0, accel = 1'b0, lsb = 1'b0;
   reg [1:0] op = 2'h0;
   reg prot_n = 1'b1;
   reg [21:0] addr = 22'h0;
   reg [15:0] wdat = 16'h0;
   reg [39:0] rows [0:3];
   wire rdy, rsp_v, done, busy, ce_n, oe_n, we_n, rst_n, word_m, pin, hv, rb_n;
   wire [15:0] rsp_d, h_dq, h_oe, f_dq;
   wire [21:0] a;
   wire [15:0] lane = (h_oe & h_dq) | (~h_oe & f_dq);
   integer err_count = 0, n_checks = 0, i, we_cnt = 0, rst_cnt = 0;
   flash_host #(.RESET_PULSE_CYC(3), .RECOVERY_CYC(2), .READY_TIMEOUT_CYC(20),
      .ACCESS_CYC(3), .WE_PULSE_CYC(2)) dut_u (
      .I_CLK(clk), .I_ARST_N(arst_n), .I_REQ_VALID(valid), .I_REQ_OP(op),
      .I_REQ_ADDR(addr), .I_REQ_ADDR_LSB(lsb), .I_REQ_DATA(wdat), .I_BYTE_MODE(byte_m),
      .I_BYPASS(bypass), .I_ACCEL_EN(accel), .I_PROTECT_N(prot_n), .O_REQ_READY(rdy),
      .O_RSP_VALID(rsp_v), .O_RSP_DATA(rsp_d), .O_RSP_DONE(done), .O_FLASH_BUSY(busy),
      .O_A(a), .O_CE_N(ce_n), .O_OE_N(oe_n), .O_WE_N(we_n), .O_RESET_N(rst_n),
      .O_WORD_MODE(word_m), .O_PROTECT_ACCEL_PIN(pin), .O_ACCEL_HIGH_VOLTAGE(hv),
      .O_DQ(h_dq), .O_DQ_OE(h_oe), .I_DQ(lane), .I_READY_BUSY_N(rb_n));
   flash_dev_model flash_u (.i_clk(clk), .i_a(a), .i_ce_n(ce_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_reset_n(rst_n), .i_word_mode(word_m), .i_dq(lane),
      .o_dq(f_dq), .o_ready_busy_n(rb_n));
   always @(posedge we_n) we_cnt = we_cnt + 1;
   always @(negedge rst_n) rst_cnt = rst_cnt + 1;
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [8*6:1] nm, input [15:0] exp, input [15:0] got);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            $display("MISMATCH %0s exp %h got %h", nm, exp, got);
            err_count = err_count + 1;
         end
      end
   endtask
   task req(input [1:0] o, input [21:0] ad, input l, input [15:0] d);
      integer k;
      begin
         k = 0;
         while (rdy !== 1'b1 && k < 3000) begin
            @(posedge clk);
            #1 k = k + 1;
         end
         chk("tmo", 16'h0, {15'h0, k >= 3000});
         we_cnt = 0;
         @(posedge clk);
         valid <= 1'b1;
         op <= o;
         addr <= ad;
         lsb <= l;
         wdat <= d;
         @(posedge clk);
         valid <= 1'b0;
         k = 0;
         while (rsp_v !== 1'b1 && done !== 1'b1 && k < 3000) begin
            @(posedge clk);
            #1 k = k + 1;
         end
         chk("tmo", 16'h0, {15'h0, k >= 3000});
      end
   endtask
   task finish_test;
      begin
         if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count = err_count + 1;
      finish_test;
   end
   initial begin
      // Row: byte width, address lsb, word address, expected read data
      rows[0] = 40'h0_0_0001_a5a1;
      rows[1] = 40'h0_0_000a_a5aa;
      rows[2] = 40'h1_0_0003_00a3;
      rows[3] = 40'h1_1_0003_00a5;
      repeat (4) @(posedge clk);
      #1 chk("wmode", 16'h1, {15'h0, word_m});
      chk("rstpin", 16'h0, {15'h0, rst_n});
      @(posedge clk);
      arst_n <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk);
         byte_m <= rows[i][36];
         req(2'h0, {6'h0, rows[i][31:16]}, rows[i][32], 16'h0);
         chk("rdata", rows[i][15:0], rsp_d);
      end
      byte_m <= 1'b0;
      // Normal, bypass and accelerated programming
      for (i = 0; i < 3; i = i + 1) begin
         @(posedge clk);
         bypass <= i == 1;
         accel <= i == 2;
         prot_n <= i != 0;
         repeat (3) @(posedge clk);
         #1 chk("hv", {15'h0, i == 2}, {15'h0, hv});
         chk("prot", {15'h0, i != 0}, {15'h0, pin});
         req(2'h2, 22'h5 + i, 1'b0, 16'h1230 + i);
         chk("wecnt", i == 0 ? 16'h4 : 16'h2, we_cnt[15:0]);
         @(posedge clk);
         accel <= 1'b0;
         bypass <= 1'b0;
         req(2'h0, 22'h5 + i, 1'b0, 16'h0);
         chk("prog", 16'h1230 + i, rsp_d);
      end
      // Flash reset issued while the model is still busy programming
      req(2'h2, 22'h8, 1'b0, 16'h4321);
      rst_cnt = 0;
      req(2'h3, 22'h0, 1'b0, 16'h0);
      chk("rstcnt", 16'h1, rst_cnt[15:0]);
      chk("busy", 16'h0, {15'h0, busy});
      req(2'h0, 22'h1, 1'b0, 16'h0);
      chk("rdata", 16'ha5a1, rsp_d);
      // Controller reset in mid-run must restart the whole flash reset sequence
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("rstpin", 16'h0, {15'h0, rst_n});
      chk("ready", 16'h0, {15'h0, rdy});
      arst_n <= 1'b1;
      req(2'h0, 22'ha, 1'b0, 16'h0);
      chk("rdata", 16'ha5aa, rsp_d);
      finish_test;
   end
endmodule // flash_bus_operation_modes_bench
